// ### rtl/pssq_pkg.sv
// Package with constants, types and register map of the preset speed and auto sequencer block.
// Functional notes
// - Mode 0 applies the selected global first or second ramp pair to all speeds.
// - Mode 1 uses each preset speed's own acceleration and deceleration times.
// - Eight preset frequencies 0.00 to 599.00 Hz; preset 0 is the keypad reference.
// - Per-speed ramp times accept 0.1 to 3600.0 seconds.
// - On/off run ramps zero to preset and back, scaled by preset over base.
// - Continuous run ramps between speeds, scaled by frequency difference over base.
// - Base is the programmable setting for pattern 7, else 50.00 or 60.00 Hz.
// - Mode 0 off; 1,4 single; 2,5 periodic; 3,6 single then hold last step.
// - Modes 1 to 3 resume the unfinished step; modes 4 to 6 restart step 0.
// - Step 0 uses the keypad preset; steps 1 to 7 own frequencies to 599.00 Hz.
// - Each step direction is 0 stop, 1 forward, 2 reverse.
// - Sequencer runs only while an input set to function 18 is asserted.
// - Single cycle runs the steps once in order, then stops the output.
// - Periodic mode restarts from step 0 after the last step, indefinitely.
// - Three inputs weighted 1, 2 and 4 select one of eight presets.
// - While sequencing, ramp times come from the selected global pair.
package pssq_pkg;
  localparam int DW = 16;
  localparam int AW = 7;
  localparam logic [3:0] GRP_MISC   = 4'h0;
  localparam logic [3:0] GRP_TERM   = 4'h1;
  localparam logic [3:0] GRP_PRESET = 4'h2;
  localparam logic [3:0] GRP_ACC    = 4'h3;
  localparam logic [3:0] GRP_DEC    = 4'h4;
  localparam logic [3:0] GRP_SFREQ  = 4'h5;
  localparam logic [3:0] GRP_STIME  = 4'h6;
  localparam logic [3:0] GRP_SDIR   = 4'h7;
  localparam logic [3:0] GRP_STAT   = 4'h8;
  localparam logic [2:0] IDX_CTRL   = 3'h0;
  localparam logic [2:0] IDX_VF     = 3'h1;
  localparam logic [2:0] IDX_BASE   = 3'h2;
  localparam logic [2:0] IDX_ACC1   = 3'h3;
  localparam logic [2:0] IDX_DEC1   = 3'h4;
  localparam logic [2:0] IDX_ACC2   = 3'h5;
  localparam logic [2:0] IDX_DEC2   = 3'h6;
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_TARGET = 3'h1;
  localparam int CTRL_PMODE_BIT = 0;
  localparam int CTRL_PAIR_BIT  = 1;
  localparam int CTRL_SEQ_LSB   = 2;
  localparam logic [DW-1:0] FREQ_MAX  = 16'hE9FC;
  localparam logic [DW-1:0] TIME_MIN  = 16'h0001;
  localparam logic [DW-1:0] TIME_MAX  = 16'h8CA0;
  localparam logic [DW-1:0] TIME_RST  = 16'h0064;
  localparam logic [DW-1:0] BASE_50   = 16'h1388;
  localparam logic [DW-1:0] BASE_60   = 16'h1770;
  localparam logic [DW-1:0] RAMP_SAT  = 16'hFFFF;
  localparam logic [DW-1:0] ZERO      = 16'h0000;
  localparam logic [3:0]    VF_PROG   = 4'h7;
  localparam logic [3:0]    VF_60_LO  = 4'h3;
  localparam logic [1:0] DIR_STOP = 2'h0;
  localparam logic [1:0] DIR_FWD  = 2'h1;
  localparam logic [1:0] DIR_REV  = 2'h2;
  localparam logic [2:0] SEQ_OFF       = 3'h0;
  localparam logic [2:0] SEQ_FRESH_LO  = 3'h4;
  localparam logic [2:0] SEQ_MODE_MAX  = 3'h6;
  localparam logic [1:0] KIND_SINGLE   = 2'h0;
  localparam logic [1:0] KIND_PERIODIC = 2'h1;
  localparam logic [1:0] KIND_HOLD     = 2'h2;
  localparam logic [4:0] FN_RUN  = 5'h00;
  localparam logic [4:0] FN_REV  = 5'h01;
  localparam logic [4:0] FN_SPD1 = 5'h02;
  localparam logic [4:0] FN_SPD2 = 5'h03;
  localparam logic [4:0] FN_SPD4 = 5'h04;
  localparam logic [4:0] FN_AUTO = 5'h12;
  localparam int TICK_NS     = 100_000_000;
  localparam int CLK_NS      = 50;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  typedef enum logic [1:0] {SQ_IDLE, SQ_RUN, SQ_HOLD, SQ_DONE} pssq_seq_state_t;
  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } pssq_bus_req_t;
  typedef struct packed {
    logic [DW-1:0] freq;
    logic [DW-1:0] ramp_time;
    logic [1:0]    dir;
  } pssq_ramp_cmd_t;
endpackage

// ### rtl/pssq_top.sv
// Preset speed selection, ramp time scaling and automatic step sequencer.
`timescale 1ns/1ps
module pssq_top #(
  parameter int TICK_CYCLES = pssq_pkg::TICK_CYCLES
) (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire pssq_pkg::pssq_bus_req_t  bus_req,
  output logic [pssq_pkg::DW-1:0]       rd_data,
  input  wire logic                     multifunction_input_a,
  input  wire logic                     multifunction_input_b,
  input  wire logic                     multifunction_input_c,
  input  wire logic                     multifunction_input_d,
  input  wire logic                     multifunction_input_e,
  output pssq_pkg::pssq_ramp_cmd_t      ramp_cmd,
  output logic                          ramp_load,
  output logic                          rotate_forward,
  output logic                          rotate_backward,
  output logic [2:0]                    seq_step,
  output logic                          seq_active
);
  import pssq_pkg::*;

  function automatic logic term_active(input logic [4:0][4:0] fn, input logic [4:0] lvl,
                                       input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (fn[i] == code && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [DW-1:0] clamp(input logic [DW-1:0] v, input logic [DW-1:0] lo,
                                          input logic [DW-1:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [1:0] seq_kind(input logic [2:0] mode);
    logic [2:0] m;
    m = (mode >= SEQ_FRESH_LO) ? 3'(mode - 3'h3) : mode;
    return 2'(m - 3'h1);
  endfunction

  logic [4:0]        pin_s1;
  logic [4:0]        pin_s2;
  logic [4:0]        pin_s3;
  logic [4:0]        term_in;
  logic [4:0][4:0]   term_fn;
  logic [DW-1:0]     preset_f [8];
  logic [DW-1:0]     acc_t    [8];
  logic [DW-1:0]     dec_t    [8];
  logic [DW-1:0]     step_f   [1:7];
  logic [DW-1:0]     step_t   [8];
  logic [1:0]        step_d   [8];
  logic              ctrl_pmode;
  logic              ctrl_pair;
  logic [2:0]        seq_mode;
  logic [3:0]        vf_sel;
  logic [DW-1:0]     base_prog;
  logic [DW-1:0]     acc1;
  logic [DW-1:0]     dec1;
  logic [DW-1:0]     acc2;
  logic [DW-1:0]     dec2;
  logic [2:0]        last_idx;
  logic [23:0]       tick_cnt;
  logic [DW-1:0]     elapsed;
  pssq_seq_state_t   seq_state;
  pssq_seq_state_t   next_state;
  logic [2:0]        next_step;
  logic [DW-1:0]     next_elapsed;
  logic [2:0]        last_w;
  logic [DW-1:0]     next_rd;

  // Input terminals pass three flops; a change counts once the last two agree.
  wire [4:0] pin_raw   = {multifunction_input_e, multifunction_input_d, multifunction_input_c,
                          multifunction_input_b, multifunction_input_a};
  wire [4:0] next_term = (pin_s2 & pin_s3) | (term_in & (pin_s2 ^ pin_s3));

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_s1  <= 5'h00;
      pin_s2  <= 5'h00;
      pin_s3  <= 5'h00;
      term_in <= 5'h00;
    end else begin
      pin_s1  <= pin_raw;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      term_in <= next_term;
    end
  end

  // Terminal functions decoded from the configured selections.
  wire       run_in    = term_active(term_fn, term_in, FN_RUN);
  wire       rev_in    = term_active(term_fn, term_in, FN_REV);
  wire [2:0] speed_idx = {term_active(term_fn, term_in, FN_SPD4),
                          term_active(term_fn, term_in, FN_SPD2),
                          term_active(term_fn, term_in, FN_SPD1)};
  wire       auto_on   = term_active(term_fn, term_in, FN_AUTO) && seq_mode != SEQ_OFF;
  wire       fresh     = seq_mode >= SEQ_FRESH_LO;
  wire [1:0] kind      = seq_kind(seq_mode);

  wire [3:0] wr_grp = bus_req.addr[6:3];
  wire [2:0] wr_idx = bus_req.addr[2:0];

  // Register writes force each field into its legal range, except vf_sel and the terminal functions, which are stored as written.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_pmode <= 1'b0;
      ctrl_pair  <= 1'b0;
      seq_mode   <= SEQ_OFF;
      vf_sel     <= 4'h0;
      base_prog  <= BASE_60;
      acc1       <= TIME_RST;
      dec1       <= TIME_RST;
      acc2       <= TIME_RST;
      dec2       <= TIME_RST;
      for (int i = 0; i < 5; i++) begin
        term_fn[i] <= 5'(i);
      end
      for (int i = 0; i < 8; i++) begin
        preset_f[i] <= ZERO;
        acc_t[i]    <= TIME_RST;
        dec_t[i]    <= TIME_RST;
        step_t[i]   <= ZERO;
        step_d[i]   <= DIR_STOP;
      end
      for (int i = 1; i < 8; i++) begin
        step_f[i] <= ZERO;
      end
    end else if (bus_req.wr) begin
      case (wr_grp)
        GRP_MISC: begin
          case (wr_idx)
            IDX_CTRL: begin
              ctrl_pmode <= bus_req.wdata[CTRL_PMODE_BIT];
              ctrl_pair  <= bus_req.wdata[CTRL_PAIR_BIT];
              seq_mode   <= (bus_req.wdata[CTRL_SEQ_LSB+:3] > SEQ_MODE_MAX) ? SEQ_OFF :
                            bus_req.wdata[CTRL_SEQ_LSB+:3];
            end
            IDX_VF:   vf_sel    <= bus_req.wdata[3:0];
            IDX_BASE: base_prog <= clamp(bus_req.wdata, TIME_MIN, FREQ_MAX);
            IDX_ACC1: acc1      <= clamp(bus_req.wdata, TIME_MIN, TIME_MAX);
            IDX_DEC1: dec1      <= clamp(bus_req.wdata, TIME_MIN, TIME_MAX);
            IDX_ACC2: acc2      <= clamp(bus_req.wdata, TIME_MIN, TIME_MAX);
            IDX_DEC2: dec2      <= clamp(bus_req.wdata, TIME_MIN, TIME_MAX);
            default: ;
          endcase
        end
        GRP_TERM:   if (wr_idx < 3'h5) term_fn[wr_idx] <= bus_req.wdata[4:0];
        GRP_PRESET: preset_f[wr_idx] <= clamp(bus_req.wdata, ZERO, FREQ_MAX);
        GRP_ACC:    acc_t[wr_idx] <= clamp(bus_req.wdata, TIME_MIN, TIME_MAX);
        GRP_DEC:    dec_t[wr_idx] <= clamp(bus_req.wdata, TIME_MIN, TIME_MAX);
        GRP_SFREQ:  if (wr_idx != 3'h0) begin
          step_f[wr_idx] <= clamp(bus_req.wdata, ZERO, FREQ_MAX);
        end
        GRP_STIME:  step_t[wr_idx] <= clamp(bus_req.wdata, ZERO, TIME_MAX);
        GRP_SDIR:   step_d[wr_idx] <= (bus_req.wdata[1:0] > DIR_REV) ? DIR_STOP :
                                      bus_req.wdata[1:0];
        default: ;
      endcase
    end
  end

  // Highest step with a nonzero running time ends the cycle.
  always_comb begin
    last_w = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (step_t[i] != ZERO) begin
        last_w = 3'(i);
      end
    end
  end

  wire tick      = tick_cnt == 24'(TICK_CYCLES - 1);
  wire step_done = elapsed >= step_t[seq_step];
  wire at_last   = seq_step == last_w;

  always_comb begin
    next_state   = seq_state;
    next_step    = seq_step;
    next_elapsed = (seq_state == SQ_RUN && tick && !step_done) ? 16'(elapsed + 16'h0001) : elapsed;
    unique case (seq_state)
      SQ_IDLE: begin
        if (auto_on) begin
          next_state = SQ_RUN;
          if (fresh) begin
            next_step    = 3'h0;
            next_elapsed = ZERO;
          end
        end
      end
      SQ_RUN: begin
        if (!auto_on) begin
          next_state = SQ_IDLE;
        end else if (step_done) begin
          next_elapsed = ZERO;
          if (!at_last) begin
            next_step = 3'(seq_step + 3'h1);
          end else if (kind == KIND_PERIODIC) begin
            next_step = 3'h0;
          end else if (kind == KIND_HOLD) begin
            next_state = SQ_HOLD;
          end else begin
            next_state = SQ_DONE;
          end
        end
      end
      SQ_HOLD, SQ_DONE: begin
        if (!auto_on) begin
          next_state   = SQ_IDLE;
          next_step    = 3'h0;
          next_elapsed = ZERO;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      seq_state <= SQ_IDLE;
      seq_step  <= 3'h0;
      elapsed   <= ZERO;
      tick_cnt  <= 24'h00_0000;
    end else begin
      seq_state <= next_state;
      seq_step  <= next_step;
      elapsed   <= next_elapsed;
      tick_cnt  <= tick ? 24'h00_0000 : 24'(tick_cnt + 24'h00_0001);
    end
  end

  // Target selection: sequencer, then stop after a single cycle, then terminals.
  wire           seq_drive = (seq_state == SQ_RUN || seq_state == SQ_HOLD) && auto_on;
  wire           seq_stop  = seq_state == SQ_DONE;
  wire [DW-1:0]  step_freq = (seq_step == 3'h0) ? preset_f[0] : step_f[seq_step];
  wire [1:0]     step_dir  = step_d[seq_step];
  wire [DW-1:0]  tgt_freq  = seq_drive ? ((step_dir == DIR_STOP) ? ZERO : step_freq) :
                             seq_stop ? ZERO : run_in ? preset_f[speed_idx] : ZERO;
  wire [1:0]     tgt_dir   = seq_drive ? step_dir : seq_stop ? DIR_STOP :
                             run_in ? (rev_in ? DIR_REV : DIR_FWD) : DIR_STOP;

  // Ramp time is the time setting scaled by the frequency step over the base.
  wire           up        = tgt_freq > ramp_cmd.freq;
  wire [DW-1:0]  delta     = up ? 16'(tgt_freq - ramp_cmd.freq) :
                             16'(ramp_cmd.freq - tgt_freq);
  wire           use_ind   = ctrl_pmode && !seq_drive && !seq_stop;
  wire [2:0]     ind_idx   = run_in ? speed_idx : last_idx;
  wire [DW-1:0]  g_acc     = ctrl_pair ? acc2 : acc1;
  wire [DW-1:0]  g_dec     = ctrl_pair ? dec2 : dec1;
  wire [DW-1:0]  time_set  = use_ind ? (up ? acc_t[ind_idx] : dec_t[ind_idx]) :
                             (up ? g_acc : g_dec);
  wire [DW-1:0]  base_w    = (vf_sel == VF_PROG) ? base_prog :
                             (vf_sel >= VF_60_LO) ? BASE_60 : BASE_50;
  wire [31:0]    scaled    = (32'(time_set) * 32'(delta)) / 32'(base_w);
  wire [DW-1:0]  ramp_w    = (scaled > 32'(RAMP_SAT)) ? RAMP_SAT : scaled[DW-1:0];
  wire           change    = tgt_freq != ramp_cmd.freq || tgt_dir != ramp_cmd.dir;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ramp_cmd        <= '{freq: ZERO, ramp_time: ZERO, dir: DIR_STOP};
      ramp_load       <= 1'b0;
      rotate_forward  <= 1'b0;
      rotate_backward <= 1'b0;
      seq_active      <= 1'b0;
      last_idx        <= 3'h0;
    end else begin
      ramp_load  <= change;
      seq_active <= seq_drive;
      if (run_in) begin
        last_idx <= speed_idx;
      end
      if (change) begin
        ramp_cmd        <= '{freq: tgt_freq, ramp_time: ramp_w, dir: tgt_dir};
        rotate_forward  <= tgt_dir == DIR_FWD;
        rotate_backward <= tgt_dir == DIR_REV;
      end
    end
  end

  // Register read-back, valid only in the cycle after the read strobe.
  always_comb begin
    next_rd = ZERO;
    case (wr_grp)
      GRP_MISC: begin
        case (wr_idx)
          IDX_CTRL: next_rd = {11'h000, seq_mode, ctrl_pair, ctrl_pmode};
          IDX_VF:   next_rd = {12'h000, vf_sel};
          IDX_BASE: next_rd = base_prog;
          IDX_ACC1: next_rd = acc1;
          IDX_DEC1: next_rd = dec1;
          IDX_ACC2: next_rd = acc2;
          IDX_DEC2: next_rd = dec2;
          default:  next_rd = ZERO;
        endcase
      end
      GRP_TERM:   next_rd = (wr_idx < 3'h5) ? {11'h000, term_fn[wr_idx]} : ZERO;
      GRP_PRESET: next_rd = preset_f[wr_idx];
      GRP_ACC:    next_rd = acc_t[wr_idx];
      GRP_DEC:    next_rd = dec_t[wr_idx];
      GRP_SFREQ:  next_rd = (wr_idx == 3'h0) ? preset_f[0] : step_f[wr_idx];
      GRP_STIME:  next_rd = step_t[wr_idx];
      GRP_SDIR:   next_rd = {14'h0000, step_d[wr_idx]};
      GRP_STAT: begin
        if (wr_idx == IDX_STATUS) begin
          next_rd = {9'h000, seq_active, term_in[4:3] != 2'h0, seq_state, seq_step};
        end else if (wr_idx == IDX_TARGET) begin
          next_rd = ramp_cmd.freq;
        end
      end
      default: next_rd = ZERO;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data <= ZERO;
    end else begin
      rd_data <= bus_req.rd ? next_rd : ZERO;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_common_pair;
    (!ctrl_pmode && up) |-> time_set == (ctrl_pair ? acc2 : acc1);
  endproperty
  a_common_pair: assert property (p_common_pair) else $error("common pair not used");
  property p_indiv_time;
    (use_ind && up && run_in) |-> time_set == acc_t[speed_idx];
  endproperty
  a_indiv_time: assert property (p_indiv_time) else $error("per-speed time not used");
  property p_freq_max;
    ramp_cmd.freq <= FREQ_MAX;
  endproperty
  a_freq_max: assert property (p_freq_max) else $error("target above 599.00 Hz");
  property p_time_clamp;
    (bus_req.wr && wr_grp == GRP_ACC) |=>
      acc_t[$past(wr_idx)] >= TIME_MIN && acc_t[$past(wr_idx)] <= TIME_MAX;
  endproperty
  a_time_clamp: assert property (p_time_clamp) else $error("ramp time out of range");
  property p_load_follow;
    change |=> ramp_load && ramp_cmd.freq == $past(tgt_freq) &&
      ramp_cmd.ramp_time == $past(ramp_w);
  endproperty
  a_load_follow: assert property (p_load_follow) else $error("ramp command not loaded");
  property p_base_fixed;
    (vf_sel != VF_PROG) |-> (base_w == BASE_50 || base_w == BASE_60);
  endproperty
  a_base_fixed: assert property (p_base_fixed) else $error("base not 50 or 60 Hz");
  property p_hold_last;
    (seq_state == SQ_RUN && auto_on && step_done && at_last && kind == KIND_HOLD) |=>
      seq_state == SQ_HOLD && seq_step == $past(seq_step);
  endproperty
  a_hold_last: assert property (p_hold_last) else $error("hold mode left last step");
  property p_fresh;
    (seq_state == SQ_IDLE && auto_on && fresh) |=> seq_step == 3'h0 && elapsed == ZERO;
  endproperty
  a_fresh: assert property (p_fresh) else $error("restart did not begin at step 0");
  property p_resume;
    (seq_state == SQ_RUN && !auto_on) |=> seq_state == SQ_IDLE && seq_step == $past(seq_step);
  endproperty
  a_resume: assert property (p_resume) else $error("pause lost the unfinished step");
  property p_dir_excl;
    !(rotate_forward && rotate_backward);
  endproperty
  a_dir_excl: assert property (p_dir_excl) else $error("both directions driven");
  property p_needs_auto;
    (seq_state == SQ_IDLE && !auto_on) |=> seq_state == SQ_IDLE;
  endproperty
  a_needs_auto: assert property (p_needs_auto) else $error("ran without auto input");
  property p_single_stop;
    (seq_state == SQ_RUN && auto_on && step_done && at_last && kind == KIND_SINGLE) |=>
      seq_state == SQ_DONE ##1 ramp_cmd.freq == ZERO;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single cycle no stop");
  property p_wrap;
    (seq_state == SQ_RUN && auto_on && step_done && at_last && kind == KIND_PERIODIC) |=>
      seq_state == SQ_RUN && seq_step == 3'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("periodic cycle did not wrap");
  property p_advance;
    (seq_state == SQ_RUN && auto_on && step_done && !at_last) |=>
      seq_step == 3'($past(seq_step) + 3'h1) && elapsed == ZERO;
  endproperty
  a_advance: assert property (p_advance) else $error("step did not advance");

  c_hold: cover property (seq_state == SQ_RUN ##1 seq_state == SQ_HOLD);
  c_done: cover property (seq_state == SQ_RUN ##1 seq_state == SQ_DONE);
  c_wrap: cover property (seq_step == last_w && last_w != 3'h0 ##1 seq_step == 3'h0);
  c_indiv: cover property (ramp_load && ctrl_pmode && !seq_active);
endmodule

// ### tb/pssq_ramp_model.sv
// Ramp generator model that follows the loaded speed command toward the power stage.
`timescale 1ns/1ps
module pssq_ramp_model
  import pssq_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           reset,
  input  wire pssq_ramp_cmd_t ramp_cmd,
  input  wire logic           ramp_load,
  output logic [DW-1:0]       out_freq,
  output logic                settled
);
  logic [DW-1:0] target;
  // Moves the output toward the latest target in fixed steps each cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      target   <= ZERO;
      out_freq <= ZERO;
    end else begin
      if (ramp_load) target <= ramp_cmd.freq;
      if (out_freq + 16'h0010 < target) out_freq <= out_freq + 16'h0010;
      else if (out_freq > target + 16'h0010) out_freq <= out_freq - 16'h0010;
      else out_freq <= target;
    end
  end
  assign settled = (out_freq == target);
endmodule

// ### tb/test_pssq_top.sv
// Self-checking testbench of the preset speed and auto sequencer block.
`timescale 1ns/1ps
module test_pssq_top;
  import pssq_pkg::*;
  logic           mclk;
  logic           reset;
  pssq_bus_req_t  bus_req;
  logic [DW-1:0]  rd_data;
  logic [4:0]     term;
  pssq_ramp_cmd_t ramp_cmd;
  logic           ramp_load;
  logic           rotate_forward;
  logic           rotate_backward;
  logic [2:0]     seq_step;
  logic           seq_active;
  logic [DW-1:0]  out_freq;
  logic           settled;
  int             err_total;
  int             n_compared;
  pssq_top #(.TICK_CYCLES(8)) i_dut (.mclk(mclk), .reset(reset), .bus_req(bus_req),
    .rd_data(rd_data), .multifunction_input_a(term[0]), .multifunction_input_b(term[1]),
    .multifunction_input_c(term[2]), .multifunction_input_d(term[3]),
    .multifunction_input_e(term[4]), .ramp_cmd(ramp_cmd), .ramp_load(ramp_load),
    .rotate_forward(rotate_forward), .rotate_backward(rotate_backward),
    .seq_step(seq_step), .seq_active(seq_active));
  pssq_ramp_model i_model (.mclk(mclk), .reset(reset), .ramp_cmd(ramp_cmd),
    .ramp_load(ramp_load), .out_freq(out_freq), .settled(settled));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    bus_req <= '0;
    #1;
    chk("rd_data", exp, rd_data);
  endtask
  // Waits for the next command load and judges every field of it.
  task automatic load(input logic [DW-1:0] f, input logic [DW-1:0] t, input logic [1:0] d);
    for (int i = 0; i < 60; i++) begin
      @(posedge mclk);
      #1;
      if (ramp_load === 1'b1) break;
    end
    chk("ramp_load", 16'h0001, {15'h0000, ramp_load});
    chk("freq", f, ramp_cmd.freq);
    chk("ramp_time", t, ramp_cmd.ramp_time);
    chk("dir", {14'h0000, d}, {14'h0000, ramp_cmd.dir});
    chk("rotate", {14'h0000, d}, {14'h0000, rotate_backward, rotate_forward});
  endtask
  // Changes the terminal levels right after a rising edge.
  task automatic drive(input logic [4:0] t);
    @(posedge mclk);
    term <= t;
  endtask
  task automatic t_regs;
    rd(7'h00, 16'h0000);
    rd(7'h03, TIME_RST);
    rd(7'h7F, 16'h0000);
    wr(7'h03, 16'h0000);
    rd(7'h03, TIME_MIN);
    wr(7'h03, 16'h0064);
    wr(7'h17, 16'hFFFF);
    rd(7'h17, FREQ_MAX);
    wr(7'h38, 16'h0003);
    rd(7'h38, 16'h0000);
    wr(7'h00, 16'h001C);
    rd(7'h00, 16'h0000);
    wr(7'h10, 16'h05DC);
    rd(7'h28, 16'h05DC);
  endtask
  task automatic t_preset;
    wr(7'h13, 16'h03E8);
    wr(7'h11, 16'h07D0);
    drive(5'b01101);
    load(16'h03E8, 16'h0014, DIR_FWD);
    drive(5'b01100);
    load(16'h0000, 16'h0014, DIR_STOP);
    wr(7'h01, 16'h0007);
    wr(7'h02, 16'h09C4);
    wr(7'h1B, 16'h01F4);
    wr(7'h00, 16'h0001);
    drive(5'b01101);
    load(16'h03E8, 16'h00C8, DIR_FWD);
    drive(5'b00101);
    load(16'h07D0, 16'h0028, DIR_FWD);
    drive(5'b00000);
    load(16'h0000, 16'h0050, DIR_STOP);
    wr(7'h01, 16'h0003);
    drive(5'b01101);
    load(16'h03E8, 16'h0053, DIR_FWD);
    drive(5'b00000);
    load(16'h0000, 16'h0010, DIR_STOP);
    wr(7'h00, 16'h0000);
    wr(7'h01, 16'h0000);
  endtask
  task automatic t_seq(input logic [2:0] mode, input logic [1:0] kind_exp);
    wr(7'h0C, 16'h0012);
    wr(7'h18, 16'h01F4);
    wr(7'h29, 16'h07D0);
    wr(7'h30, 16'h0002);
    wr(7'h31, 16'h0002);
    wr(7'h38, 16'h0001);
    wr(7'h39, 16'h0002);
    wr(7'h00, {11'h000, mode, 2'b01});
    drive(5'b10000);
    load(16'h05DC, 16'h001E, DIR_FWD);
    chk("seq_step", 16'h0000, {13'h0000, seq_step});
    chk("seq_active", 16'h0001, {15'h0000, seq_active});
    load(16'h07D0, 16'h000A, DIR_REV);
    chk("seq_step", 16'h0001, {13'h0000, seq_step});
    drive(5'b00000);
    load(16'h0000, 16'h0028, DIR_STOP);
    drive(5'b10000);
    if (mode >= 3'h4) begin
      load(16'h05DC, 16'h001E, DIR_FWD);
      chk("seq_step", 16'h0000, {13'h0000, seq_step});
      load(16'h07D0, 16'h000A, DIR_REV);
    end else begin
      load(16'h07D0, 16'h0028, DIR_REV);
      chk("seq_step", 16'h0001, {13'h0000, seq_step});
    end
    if (kind_exp == KIND_PERIODIC) load(16'h05DC, 16'h000A, DIR_FWD);
    else if (kind_exp == KIND_SINGLE) load(16'h0000, 16'h0028, DIR_STOP);
    else begin
      repeat (40) @(posedge mclk);
      #1;
      chk("hold_freq", 16'h07D0, ramp_cmd.freq);
      chk("hold_active", 16'h0001, {15'h0000, seq_active});
      rd(7'h40, 16'h0071);
    end
    drive(5'b00000);
    repeat (30) @(posedge mclk);
    wr(7'h00, 16'h0000);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_total++;
    results;
  end
  initial begin
    err_total = 0;
    n_compared = 0;
    reset = 1'b1;
    bus_req = '0;
    term = 5'b00000;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    t_regs;
    t_preset;
    t_seq(3'h1, KIND_SINGLE);
    t_seq(3'h5, KIND_PERIODIC);
    t_seq(3'h6, KIND_HOLD);
    results;
  end
endmodule
